// [hdl/hbe_pkg.sv]
package hbe_pkg;

  // register byte offsets
  localparam logic [7:0] HBE_OFF_STATUS    = 8'h00; // error_interrupt_status
  localparam logic [7:0] HBE_OFF_ERR_CS    = 8'h04; // host_bus_error_ctrl_status
  localparam logic [7:0] HBE_OFF_ADDR_LOG  = 8'h08; // host_bus_address_error_log
  localparam logic [7:0] HBE_OFF_MISC      = 8'h0c; // host_bus_misc_control

  // error_interrupt_status bit positions
  localparam int HBE_NFLAGS           = 9;
  localparam int HBE_F_ADDR_PAR       = 0;
  localparam int HBE_F_DPAR_P1        = 1;
  localparam int HBE_F_DPAR_P2        = 2;
  localparam int HBE_F_DPAR_LOCAL     = 3;
  localparam int HBE_F_BUSERR_P1      = 4;
  localparam int HBE_F_BUSERR_P2      = 5;
  localparam int HBE_F_BUSERR_LOCAL   = 6;
  localparam int HBE_F_RETRY_P1       = 7;
  localparam int HBE_F_RETRY_P2       = 8;

  // host_bus_error_ctrl_status fields
  localparam int HBE_CS_ES            = 0;
  localparam int HBE_CS_SRC_SLAVE     = 1;
  localparam int HBE_CS_TT_LSB        = 8;
  localparam int HBE_CS_TSIZ_LSB      = 16;

  // host_bus_misc_control fields and reset
  localparam int HBE_MISC_TRANSFER_ERROR_ACK_ENABLE      = 0;
  localparam int HBE_MISC_LE_MODE     = 1;
  localparam logic HBE_TRANSFER_ERROR_ACK_ENABLE_RST     = 1'b0;
  localparam logic HBE_LE_MODE_RST    = 1'b0;

  // largest single beat allowed for cfg/io/iack and register access
  localparam logic [3:0] HBE_MAX_SINGLE_BYTES = 4'h4;

  // port codes for slave destination and master source
  localparam logic [1:0] HBE_PORT_P1    = 2'h0;
  localparam logic [1:0] HBE_PORT_P2    = 2'h1;
  localparam logic [1:0] HBE_PORT_LOCAL = 2'h2; // registers on slave side

  // slave access kinds
  localparam logic [1:0] HBE_KIND_MEM   = 2'h0;
  localparam logic [1:0] HBE_KIND_CIO   = 2'h1; // cfg, io, interrupt ack
  localparam logic [1:0] HBE_KIND_AONLY = 2'h2;

  localparam logic [1:0] HBE_RESP_OKAY   = 2'h0;
  localparam logic [1:0] HBE_RESP_SLVERR = 2'h2;

endpackage : hbe_pkg

// [hdl/hbe_sticky_flags.sv]
module hbe_sticky_flags #(
  parameter int W = 9
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] set_vec,
  input  wire logic [W-1:0] clr_vec,
  output logic      [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } hbe_flag_state_t;

  hbe_flag_state_t st_q;
  hbe_flag_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (ce) begin
      // set after clear: an event in the clearing cycle survives
      st_d.flags = (st_q.flags & ~clr_vec) | set_vec;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;

  chk_flags_stay_set: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> (($past(flags) & ~$past(clr_vec) & ~flags) == '0))
    else $error("sticky flag dropped without a clear");

endmodule : hbe_sticky_flags

// [hdl/hbe_error_reporter.sv]
// Functional notes
// - the slave checks address parity, data parity and bus errors; the master checks data parity, bus errors and retry exhaustion.
// - a master-detected error sets a flag selected by the transaction's source port.
// - a slave data parity or illegal-access error sets a flag selected by the transaction's destination port.
// - a slave address parity error sets the slave address parity flag for any cycle kind.
// - slave write data parity sets port-1 flag for port 1 or registers, port-2 flag for port 2.
// - an unaligned memory access in little-endian mode is illegal and sets that port's error.
// - cfg/io/iack or register access is illegal if unaligned in le mode, over 4 bytes or burst.
// - the error acknowledge is driven for illegal accesses and failed reads only when enabled.
// - on an error the transfer type and size go to the control log, the address to the address log.
// - every listed master and slave error case triggers the log capture.
// - master read data parity sets the data parity flag of the source.
// - a master transfer ended by an external error acknowledge sets the source's bus error flag.
// - retry exhaustion on a port-1 or port-2 transaction sets that port's retry flag.
// - with the acknowledge disabled, illegal transactions are not forwarded but flags still set.
// - a slave address parity error makes the device decline the transaction.
// - clearing a status flag negates the interrupt level driven from it.
module hbe_error_reporter #(
  parameter int AXI_ADDR_W = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  // axi4-lite register slave
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // slave-side transaction report, one cycle per transaction
  input  wire logic                  slv_valid,
  input  wire logic [1:0]            slv_dest,
  input  wire logic [1:0]            slv_kind,
  input  wire logic                  slv_write,
  input  wire logic                  slv_read,
  input  wire logic                  slv_burst,
  input  wire logic [3:0]            slv_bytes,
  input  wire logic [4:0]            slv_host_transfer_type,
  input  wire logic [2:0]            slv_host_transfer_size,
  input  wire logic [31:0]           slv_host_address_lines,
  input  wire logic                  slv_addr_par_err,
  input  wire logic                  slv_data_par_err,
  input  wire logic                  slv_dest_err,
  output logic                       slv_claim,
  output logic                       slv_forward,
  output logic                       transfer_error_ack_n,
  // master-side transaction report, one cycle per completed transaction
  input  wire logic                  mst_valid,
  input  wire logic [1:0]            mst_source,
  input  wire logic                  mst_read,
  input  wire logic [4:0]            mst_host_transfer_type,
  input  wire logic [2:0]            mst_host_transfer_size,
  input  wire logic [31:0]           mst_host_address_lines,
  input  wire logic                  mst_data_par_err,
  input  wire logic                  mst_tea_in,
  input  wire logic                  mst_retry_expired,
  // status level per flag, for external interrupt mapping
  output logic [hbe_pkg::HBE_NFLAGS-1:0] error_interrupt_status
);
  import hbe_pkg::*;

  typedef struct packed {
    logic                  aw_got;
    logic [7:0]            aw_addr;
    logic                  w_got;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  transfer_error_ack_enable;
    logic                  le_mode;
    logic                  es;
    logic                  src_slave;
    logic [4:0]            log_tt;
    logic [2:0]            log_tsiz;
    logic [31:0]           log_addr;
    logic                  tea_n;
  } hbe_state_t;

  hbe_state_t st_q;
  hbe_state_t st_d;

  logic [HBE_NFLAGS-1:0] flag_set;
  logic [HBE_NFLAGS-1:0] flag_clr;
  logic [HBE_NFLAGS-1:0] flags;
  logic                  wr_fire;
  logic [7:0]            ar_addr;
  logic [3:0]            bytes_m1;
  logic                  unaligned;
  logic                  too_big;
  logic                  illegal;
  logic                  claimed;
  logic                  tea_fire;
  logic                  slv_err;
  logic                  mst_err;
  logic [31:0]           lane_mask;

  assign ar_addr  = 8'(s_axi_araddr);
  assign wr_fire  = st_q.aw_got && st_q.w_got && !st_q.bvalid;
  assign bytes_m1 = 4'(slv_bytes - 4'h1);
  assign lane_mask = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}},
                      {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};

  // alignment only matters in little-endian mode; sizes that are not a power of two never align
  always_comb begin
    unaligned = 1'b0;
    if (st_q.le_mode && slv_bytes != 4'h0) begin
      unaligned = ((slv_bytes & bytes_m1) != 4'h0) ||
                  ((slv_host_address_lines[3:0] & bytes_m1) != 4'h0);
    end
  end

  assign too_big = (slv_bytes > HBE_MAX_SINGLE_BYTES) || slv_burst;

  always_comb begin
    illegal = 1'b0;
    if (slv_dest != HBE_PORT_LOCAL && slv_kind == HBE_KIND_MEM) begin
      illegal = unaligned;
    end else if (slv_kind != HBE_KIND_AONLY) begin
      illegal = unaligned || too_big;
    end
  end

  assign claimed     = slv_valid && !slv_addr_par_err;
  assign slv_claim   = claimed;
  // refused accesses never reach the port or registers, enable or not
  assign slv_forward = claimed && !illegal;

  assign tea_fire = st_q.transfer_error_ack_enable && claimed &&
                    (illegal || (slv_read && slv_dest_err && slv_dest != HBE_PORT_LOCAL));

  // flag set vector
  always_comb begin
    flag_set = '0;
    if (slv_valid && slv_addr_par_err) begin
      flag_set[HBE_F_ADDR_PAR] = 1'b1;
    end
    if (claimed && slv_write && slv_data_par_err) begin
      if (slv_dest == HBE_PORT_P2) begin
        flag_set[HBE_F_DPAR_P2] = 1'b1;
      end else begin
        flag_set[HBE_F_DPAR_P1] = 1'b1;
      end
    end
    if (claimed && illegal) begin
      if (slv_dest == HBE_PORT_P2) begin
        flag_set[HBE_F_BUSERR_P2] = 1'b1;
      end else begin
        flag_set[HBE_F_BUSERR_P1] = 1'b1;
      end
    end
    if (mst_valid) begin
      case (mst_source)
        HBE_PORT_P1: begin
          // slave dpar to port 1 and master dpar from port 1 may coincide
          flag_set[HBE_F_DPAR_P1]   = flag_set[HBE_F_DPAR_P1] | (mst_read && mst_data_par_err);
          flag_set[HBE_F_BUSERR_P1] = flag_set[HBE_F_BUSERR_P1] | mst_tea_in;
          flag_set[HBE_F_RETRY_P1]  = mst_retry_expired;
        end
        HBE_PORT_P2: begin
          flag_set[HBE_F_DPAR_P2]   = flag_set[HBE_F_DPAR_P2] | (mst_read && mst_data_par_err);
          flag_set[HBE_F_BUSERR_P2] = flag_set[HBE_F_BUSERR_P2] | mst_tea_in;
          flag_set[HBE_F_RETRY_P2]  = mst_retry_expired;
        end
        HBE_PORT_LOCAL: begin
          flag_set[HBE_F_DPAR_LOCAL]   = mst_read && mst_data_par_err;
          flag_set[HBE_F_BUSERR_LOCAL] = mst_tea_in;
        end
        default: begin
        end
      endcase
    end
  end

  assign slv_err = slv_valid && (slv_addr_par_err || (slv_write && slv_data_par_err) ||
                   illegal || (slv_read && slv_dest_err && slv_dest != HBE_PORT_LOCAL));
  assign mst_err = mst_valid && ((mst_read && mst_data_par_err) || mst_tea_in ||
                   (mst_retry_expired && mst_source != HBE_PORT_LOCAL));

  // write-one-to-clear on the status register
  assign flag_clr = (wr_fire && st_q.aw_addr[7:2] == HBE_OFF_STATUS[7:2]) ?
                    HBE_NFLAGS'(st_q.wdata & lane_mask) : '0;

  always_comb begin
    st_d = st_q;
    if (ce) begin
      // write channels, taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
        st_d.aw_got  = 1'b1;
        st_d.aw_addr = 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        st_d.w_got = 1'b1;
        st_d.wdata = s_axi_wdata;
        st_d.wstrb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
        st_d.bvalid = 1'b0;
      end
      if (wr_fire) begin
        st_d.aw_got = 1'b0;
        st_d.w_got  = 1'b0;
        st_d.bvalid = 1'b1;
        st_d.bresp  = HBE_RESP_OKAY;
        case (st_q.aw_addr[7:2])
          HBE_OFF_STATUS[7:2]: begin
          end
          HBE_OFF_ERR_CS[7:2]: begin
            if (st_q.wstrb[0] && st_q.wdata[HBE_CS_ES]) begin
              st_d.es = 1'b0;
            end
          end
          HBE_OFF_ADDR_LOG[7:2]: begin
          end
          HBE_OFF_MISC[7:2]: begin
            if (st_q.wstrb[0]) begin
              st_d.transfer_error_ack_enable  = st_q.wdata[HBE_MISC_TRANSFER_ERROR_ACK_ENABLE];
              st_d.le_mode = st_q.wdata[HBE_MISC_LE_MODE];
            end
          end
          default: st_d.bresp = HBE_RESP_SLVERR;
        endcase
      end
      // read channel
      if (st_q.rvalid && s_axi_rready) begin
        st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        st_d.rvalid = 1'b1;
        st_d.rresp  = HBE_RESP_OKAY;
        st_d.rdata  = '0;
        case (ar_addr[7:2])
          HBE_OFF_STATUS[7:2]:   st_d.rdata[HBE_NFLAGS-1:0] = flags;
          HBE_OFF_ERR_CS[7:2]: begin
            st_d.rdata[HBE_CS_ES]                     = st_q.es;
            st_d.rdata[HBE_CS_SRC_SLAVE]              = st_q.src_slave;
            st_d.rdata[HBE_CS_TT_LSB +: 5]            = st_q.log_tt;
            st_d.rdata[HBE_CS_TSIZ_LSB +: 3]          = st_q.log_tsiz;
          end
          HBE_OFF_ADDR_LOG[7:2]: st_d.rdata = st_q.log_addr;
          HBE_OFF_MISC[7:2]: begin
            st_d.rdata[HBE_MISC_TRANSFER_ERROR_ACK_ENABLE]  = st_q.transfer_error_ack_enable;
            st_d.rdata[HBE_MISC_LE_MODE] = st_q.le_mode;
          end
          default: st_d.rresp = HBE_RESP_SLVERR;
        endcase
      end
      // log holds the first error until software clears es; an error in the cycle that clears es is lost
      if (!st_q.es && (slv_err || mst_err)) begin
        st_d.es = 1'b1;
        st_d.src_slave = slv_err;
        if (slv_err) begin
          st_d.log_tt   = slv_host_transfer_type;
          st_d.log_tsiz = slv_host_transfer_size;
          st_d.log_addr = slv_host_address_lines;
        end else begin
          st_d.log_tt   = mst_host_transfer_type;
          st_d.log_tsiz = mst_host_transfer_size;
          st_d.log_addr = mst_host_address_lines;
        end
      end
      st_d.tea_n = !tea_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= '0;
      st_q.transfer_error_ack_enable  <= HBE_TRANSFER_ERROR_ACK_ENABLE_RST;
      st_q.le_mode <= HBE_LE_MODE_RST;
      st_q.tea_n   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  hbe_sticky_flags #(
    .W (HBE_NFLAGS)
  ) u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .set_vec (flag_set),
    .clr_vec (flag_clr),
    .flags   (flags)
  );

  // ready gated by ce so nothing is taken while frozen
  assign s_axi_awready = ce && !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready  = ce && !st_q.w_got && !st_q.bvalid;
  assign s_axi_arready = ce && !st_q.rvalid;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign transfer_error_ack_n   = st_q.tea_n;
  assign error_interrupt_status = flags;

  chk_decline_addr_par: assert property (@(posedge aclk) disable iff (!aresetn)
    slv_valid && slv_addr_par_err |-> !slv_claim && !slv_forward)
    else $error("transaction claimed despite address parity error");

  chk_no_fwd_illegal: assert property (@(posedge aclk) disable iff (!aresetn)
    slv_valid && illegal |-> !slv_forward)
    else $error("illegal access forwarded");

  chk_tea_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !st_q.transfer_error_ack_enable |=> transfer_error_ack_n)
    else $error("error acknowledge driven while disabled");

  chk_tea_illegal: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st_q.transfer_error_ack_enable && claimed && illegal |=> !transfer_error_ack_n)
    else $error("illegal access not acknowledged with error");

  chk_addr_par_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && slv_valid && slv_addr_par_err |=> error_interrupt_status[HBE_F_ADDR_PAR])
    else $error("address parity flag not set");

  chk_slv_dpar_p2: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && claimed && slv_write && slv_data_par_err && slv_dest == HBE_PORT_P2
      |=> error_interrupt_status[HBE_F_DPAR_P2])
    else $error("port-2 data parity flag not set");

  chk_retry_p1: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mst_valid && mst_retry_expired && mst_source == HBE_PORT_P1
      |=> error_interrupt_status[HBE_F_RETRY_P1])
    else $error("port-1 retry flag not set");

  chk_mst_tea_local: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mst_valid && mst_tea_in && mst_source == HBE_PORT_LOCAL
      |=> error_interrupt_status[HBE_F_BUSERR_LOCAL])
    else $error("local bus error flag not set");

  chk_log_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !st_q.es && slv_err |=> st_q.es && st_q.src_slave &&
      st_q.log_addr == $past(slv_host_address_lines) &&
      st_q.log_tt == $past(slv_host_transfer_type))
    else $error("slave error not logged");

endmodule : hbe_error_reporter

// [bench/hbe_bus_agent.sv]
module hbe_bus_agent (
  input  wire logic   aclk,
  input  wire logic   slv_claim,
  input  wire logic   slv_forward,
  input  wire logic   transfer_error_ack_n,
  output logic        slv_valid,
  output logic [1:0]  slv_dest,
  output logic [1:0]  slv_kind,
  output logic        slv_write,
  output logic        slv_read,
  output logic        slv_burst,
  output logic [3:0]  slv_bytes,
  output logic [4:0]  slv_host_transfer_type,
  output logic [2:0]  slv_host_transfer_size,
  output logic [31:0] slv_host_address_lines,
  output logic        slv_addr_par_err,
  output logic        slv_data_par_err,
  output logic        slv_dest_err,
  output logic        mst_valid,
  output logic [1:0]  mst_source,
  output logic        mst_read,
  output logic [4:0]  mst_host_transfer_type,
  output logic [2:0]  mst_host_transfer_size,
  output logic [31:0] mst_host_address_lines,
  output logic        mst_data_par_err,
  output logic        mst_tea_in,
  output logic        mst_retry_expired
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [53:0] sv;
  logic [45:0] mv;

  assign {slv_dest, slv_kind, slv_write, slv_read, slv_burst, slv_bytes, slv_host_transfer_type,
          slv_host_transfer_size, slv_host_address_lines, slv_addr_par_err, slv_data_par_err,
          slv_dest_err} = sv;
  assign {mst_source, mst_read, mst_host_transfer_type, mst_host_transfer_size,
          mst_host_address_lines, mst_data_par_err, mst_tea_in, mst_retry_expired} = mv;

  initial begin
    slv_valid = 1'b0;
    mst_valid = 1'b0;
    sv = '0;
    mv = '0;
  end

  // unqualified fields flip after each beat so stale values never look valid
  task slv_op(input logic [1:0] d, k, input logic w, b, input logic [3:0] n,
              input logic [4:0] tt, input logic [2:0] ts, input logic [31:0] a,
              input logic ap, dp, de, output logic cl, fw, ak);
    @(posedge aclk);
    slv_valid <= 1'b1;
    sv <= {d, k, w, ~w, b, n, tt, ts, a, ap, dp, de};
    #1;
    cl = slv_claim;
    fw = slv_forward;
    @(posedge aclk);
    slv_valid <= 1'b0;
    sv <= ~sv;
    #1;
    ak = transfer_error_ack_n;
  endtask : slv_op

  task mst_op(input logic [1:0] s, input logic r, input logic [4:0] tt, input logic [2:0] ts,
              input logic [31:0] a, input logic dp, te, rt);
    @(posedge aclk);
    mst_valid <= 1'b1;
    mv <= {s, r, tt, ts, a, dp, te, rt};
    @(posedge aclk);
    mst_valid <= 1'b0;
    mv <= ~mv;
    #1;
  endtask : mst_op
endmodule : hbe_bus_agent

// [bench/tb_hbe_error_reporter.sv]
module tb_hbe_error_reporter;
  timeunit 1ns;
  timeprecision 1ps;
  import hbe_pkg::*;
  localparam logic [1:0] P1 = HBE_PORT_P1;
  localparam logic [1:0] P2 = HBE_PORT_P2;
  localparam logic [1:0] L = HBE_PORT_LOCAL;
  localparam logic [1:0] M = HBE_KIND_MEM;
  localparam logic [1:0] C = HBE_KIND_CIO;
  logic aclk = 1'b0;
  logic aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic slv_valid, slv_write, slv_read, slv_burst, slv_addr_par_err, slv_data_par_err;
  logic slv_dest_err, slv_claim, slv_forward, transfer_error_ack_n, mst_valid, mst_read;
  logic mst_data_par_err, mst_tea_in, mst_retry_expired, cl, fw, ak;
  logic [1:0]            s_axi_bresp, s_axi_rresp, slv_dest, slv_kind, mst_source, rs;
  logic [2:0]            slv_host_transfer_size, mst_host_transfer_size;
  logic [3:0]            s_axi_wstrb, slv_bytes;
  logic [4:0]            slv_host_transfer_type, mst_host_transfer_type;
  logic [7:0]            s_axi_awaddr, s_axi_araddr;
  logic [HBE_NFLAGS-1:0] error_interrupt_status;
  logic [31:0] s_axi_wdata, s_axi_rdata, slv_host_address_lines, mst_host_address_lines, rd;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  hbe_error_reporter uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .slv_valid, .slv_dest, .slv_kind, .slv_write, .slv_read,
    .slv_burst, .slv_bytes, .slv_host_transfer_type, .slv_host_transfer_size,
    .slv_host_address_lines, .slv_addr_par_err, .slv_data_par_err, .slv_dest_err, .slv_claim,
    .slv_forward, .transfer_error_ack_n, .mst_valid, .mst_source, .mst_read,
    .mst_host_transfer_type, .mst_host_transfer_size, .mst_host_address_lines,
    .mst_data_par_err, .mst_tea_in, .mst_retry_expired, .error_interrupt_status);

  hbe_bus_agent agent (.aclk, .slv_claim, .slv_forward, .transfer_error_ack_n, .slv_valid,
    .slv_dest, .slv_kind, .slv_write, .slv_read, .slv_burst, .slv_bytes,
    .slv_host_transfer_type, .slv_host_transfer_size, .slv_host_address_lines,
    .slv_addr_par_err, .slv_data_par_err, .slv_dest_err, .mst_valid, .mst_source, .mst_read,
    .mst_host_transfer_type, .mst_host_transfer_size, .mst_host_address_lines,
    .mst_data_par_err, .mst_tea_in, .mst_retry_expired);

  always #10 aclk = ~aclk;

  // whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end

  task results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task chk(input string n, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // address and data may be taken on different edges
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready === 1'b1) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task clr;
    axw(HBE_OFF_STATUS, 32'h0000_01ff);
    axw(HBE_OFF_ERR_CS, 32'h0000_0001);
  endtask : clr

  // e holds expected claim, forward, ack_n
  task sc(input logic [1:0] d, k, input logic w, b, input logic [3:0] n, input logic [31:0] a,
          input logic ap, dp, de, input logic [2:0] e, input logic [8:0] f);
    agent.slv_op(d, k, w, b, n, 5'h0a, 3'h2, a, ap, dp, de, cl, fw, ak);
    chk("slave_response", {29'h0, cl, fw, ak}, {29'h0, e});
    chk("flags", {23'h0, error_interrupt_status}, {23'h0, f});
    clr();
  endtask : sc

  task mc(input logic [1:0] s, input logic r, dp, te, rt, input logic [8:0] f);
    agent.mst_op(s, r, 5'h11, 3'h1, 32'h0000_0100, dp, te, rt);
    chk("flags", {23'h0, error_interrupt_status}, {23'h0, f});
    clr();
  endtask : mc

  initial begin
    {aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    ce = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk("flags", {23'h0, error_interrupt_status}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      axr(8'(i * 4));
      chk("read_data", rd, 32'h0);
      chk("read_resp", {30'h0, rs}, {30'h0, (i == 4) ? HBE_RESP_SLVERR : HBE_RESP_OKAY});
    end
    axw(8'h14, 32'hffff_ffff);
    chk("write_resp", {30'h0, rs}, {30'h0, HBE_RESP_SLVERR});
    $display("test reset done");
    axw(HBE_OFF_MISC, 32'h0000_0003);
    sc(P1, M, 1, 0, 4'h4, 32'h2, 0, 0, 0, 3'b100, 9'h010);
    sc(P2, M, 0, 0, 4'h3, 32'h0, 0, 0, 0, 3'b100, 9'h020);
    sc(P1, M, 1, 0, 4'h8, 32'h0, 0, 0, 0, 3'b111, 9'h000);
    sc(P2, C, 1, 0, 4'h8, 32'h0, 0, 0, 0, 3'b100, 9'h020);
    sc(P1, C, 0, 0, 4'h2, 32'h1, 0, 0, 0, 3'b100, 9'h010);
    sc(L, M, 1, 1, 4'h4, 32'h0, 0, 0, 0, 3'b100, 9'h010);
    sc(P1, C, 1, 0, 4'h4, 32'h4, 0, 0, 0, 3'b111, 9'h000);
    sc(P1, M, 0, 0, 4'h4, 32'h0, 0, 0, 1, 3'b110, 9'h000);
    sc(P2, HBE_KIND_AONLY, 0, 0, 4'h0, 32'h3, 1, 0, 0, 3'b001, 9'h001);
    sc(L, M, 0, 0, 4'h4, 32'h0, 1, 0, 0, 3'b001, 9'h001);
    sc(P1, M, 1, 0, 4'h4, 32'h0, 0, 1, 0, 3'b111, 9'h002);
    sc(L, M, 1, 0, 4'h4, 32'h0, 0, 1, 0, 3'b111, 9'h002);
    sc(P2, M, 1, 0, 4'h4, 32'h0, 0, 1, 0, 3'b111, 9'h004);
    axw(HBE_OFF_MISC, 32'h0000_0002);
    sc(P1, M, 1, 0, 4'h4, 32'h2, 0, 0, 0, 3'b101, 9'h010);
    sc(P2, M, 0, 0, 4'h4, 32'h0, 0, 0, 1, 3'b111, 9'h000);
    axw(HBE_OFF_MISC, 32'h0000_0001);
    sc(P1, M, 1, 0, 4'h3, 32'h1, 0, 0, 0, 3'b111, 9'h000);
    sc(P1, C, 1, 0, 4'h8, 32'h0, 0, 0, 0, 3'b100, 9'h010);
    $display("test slave done");
    mc(P1, 1, 1, 0, 0, 9'h002);
    mc(P2, 1, 1, 0, 0, 9'h004);
    mc(L, 1, 1, 0, 0, 9'h008);
    mc(P1, 0, 1, 0, 0, 9'h000);
    mc(P1, 0, 0, 1, 0, 9'h010);
    mc(P2, 1, 0, 1, 0, 9'h020);
    mc(L, 0, 0, 1, 0, 9'h040);
    mc(P1, 0, 0, 0, 1, 9'h080);
    mc(P2, 1, 0, 0, 1, 9'h100);
    mc(L, 1, 0, 0, 1, 9'h000);
    $display("test master done");
    // second error must not overwrite the first log entry
    agent.slv_op(P2, HBE_KIND_AONLY, 0, 0, 4'h0, 5'h15, 3'h5, 32'h1234_5678, 1, 0, 0, cl, fw, ak);
    agent.mst_op(P1, 1, 5'h03, 3'h2, 32'hdead_0000, 1, 0, 0);
    chk("flags", {23'h0, error_interrupt_status}, 32'h0000_0003);
    axr(HBE_OFF_ERR_CS);
    chk("err_cs", rd, 32'h0005_1503);
    axr(HBE_OFF_ADDR_LOG);
    chk("addr_log", rd, 32'h1234_5678);
    clr();
    agent.mst_op(P2, 0, 5'h1e, 3'h3, 32'h0bad_f00d, 0, 1, 0);
    axr(HBE_OFF_ERR_CS);
    chk("err_cs", rd, 32'h0003_1e01);
    axr(HBE_OFF_ADDR_LOG);
    chk("addr_log", rd, 32'h0bad_f00d);
    clr();
    $display("test log done");
    agent.mst_op(P1, 0, 5'h01, 3'h2, 32'h0, 0, 1, 0);
    agent.slv_op(P1, M, 1, 0, 4'h4, 5'h01, 3'h2, 32'h0, 0, 0, 0, cl, fw, ak);
    axw(HBE_OFF_STATUS, 32'h0000_01ef);
    chk("flags", {23'h0, error_interrupt_status}, 32'h0000_0010);
    axr(HBE_OFF_STATUS);
    chk("status", rd, 32'h0000_0010);
    axw(HBE_OFF_STATUS, 32'h0000_0010);
    chk("flags", {23'h0, error_interrupt_status}, 32'h0);
    $display("test sticky done");
    results();
  end
endmodule : tb_hbe_error_reporter
